/* design/zsm_defines.svh */
/*
 Register offsets, reset values and field positions of the zone select and readback
 monitor block. Assumes inclusion by bare name from design files.
*/
`ifndef ZSM_DEFINES_SVH
`define ZSM_DEFINES_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ZSM_IDX_WHITE_PIXEL_COUNT_1   8'hc5
`define ZSM_IDX_WHITE_PIXEL_COUNT_2   8'hc6
`define ZSM_IDX_ZONE_SELECT_1_TO_4    8'hd1
`define ZSM_IDX_ZONE_SELECT_5_TO_8    8'hd2
`define ZSM_IDX_ZONE_SELECT_9_TO_12   8'hd3
`define ZSM_IDX_ZONE_SELECT_13_TO_16  8'hd4
`define ZSM_IDX_OVERLAY_SHIFT_SELECT  8'heb
`define ZSM_IDX_SERIAL_INPUT_MONITOR  8'hed
`define ZSM_IDX_OVERLAY_ONE_MONITOR   8'hee
`define ZSM_IDX_OVERLAY_TWO_MONITOR   8'hef

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ZSM_RST_WHITE_PIXEL_COUNT_1   8'h64
`define ZSM_RST_WHITE_PIXEL_COUNT_2   8'h80
`define ZSM_RST_ZONE_SELECT           8'hff
`define ZSM_RST_OVERLAY_SHIFT_SELECT  8'h00

// ----------------------------------------------------------------------------
// field positions and monitor selector codes
// ----------------------------------------------------------------------------
`define ZSM_FUNC_MSB                  7
`define ZSM_FUNC_LSB                  6
`define ZSM_SEL_OVERLAY_CONTROL       4'h0
`define ZSM_SEL_OVERLAY_ONE_BITMAP    4'h1
`define ZSM_SEL_WIN2_LSBS             4'h5
`define ZSM_SEL_LINE_MEM_2            4'h6

`endif

/* design/zsm_monitor_regs.sv */
/*
 APB register bank: white pixel counts, zone select, overlay shift select and three
 read-only monitors steered by monitor_selector.
 Assumes monitor sources and monitor_selector come from logic on pclk.
 Assumes a master that holds each request until pready is seen high.
 Assertions sit at the end, grouped by the behaviour they guard.
*/
`timescale 1ns/10ps
`include "zsm_defines.svh"

// Contract
// - four zone-select registers, four 2-bit fields each, lowest zone in bits 1:0
// - first monitor returns serial input byte chosen by monitor selector
// - selector 0000 on second monitor gives overlay control; 0x means function off
// - second monitor reports overlay bitmap 1 control, opacity in bits 7:6
// - third monitor packs window 2 low bits: vstart, vstop, hstart, hstop
// - selector 0110 on third monitor gives overlay 2 line memory length
// - overlay shift select is read/write and resets to 00
module zsm_monitor_regs
   import zsm_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic                  pready,
   output logic                  pslverr,
   output logic      [31:0]      prdata,
   // monitor sources
   input  wire logic [3:0]       monitor_selector,
   input  wire zsm_byte_type [15:0] serial_input_bytes,
   input  wire zsm_byte_type [15:0] overlay_one_sources,
   input  wire zsm_byte_type [15:0] overlay_two_sources,
   input  wire logic [1:0]       win2_vstart_lsbs,
   input  wire logic [1:0]       win2_vstop_lsbs,
   input  wire logic [1:0]       win2_hstart_lsbs,
   input  wire logic [1:0]       win2_hstop_lsbs,
   input  wire zsm_byte_type     line_mem_len_2,
   // configuration out
   output zsm_byte_type          white_pixel_count_1,
   output zsm_byte_type          white_pixel_count_2,
   output logic      [31:0]      zone_mode,
   output zsm_byte_type          overlay_shift_select,
   output logic                  overlay_function_on
);

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   function automatic logic addr_hit(input logic [11:0] a, input logic [7:0] idx);
      addr_hit = (a == {2'b00, idx, 2'b00});
   endfunction

   zsm_state_type st_r;
   zsm_state_type st_nxt;
   logic          access;
   logic          wr_en;
   logic          mapped;
   zsm_byte_type  mon_one;
   zsm_byte_type  mon_two;
   zsm_byte_type  rd_byte;
   zsm_byte_type  func_src;

   assign access = psel && penable && !st_r.pready_r;
   assign wr_en  = access && pwrite && pstrb[0];

   // ----------------------------------------------------------------------------
   // monitor multiplexers
   // ----------------------------------------------------------------------------
   always_comb begin
      mon_one = overlay_one_sources[monitor_selector];
      mon_two = overlay_two_sources[monitor_selector];
      if (monitor_selector == `ZSM_SEL_WIN2_LSBS) begin
         mon_two = {win2_vstart_lsbs, win2_vstop_lsbs,
                    win2_hstart_lsbs, win2_hstop_lsbs};
      end else if (monitor_selector == `ZSM_SEL_LINE_MEM_2) begin
         mon_two = line_mem_len_2;
      end
   end

   // overlay control byte is always the selector-0 source, independent of reads
   assign func_src = overlay_one_sources[`ZSM_SEL_OVERLAY_CONTROL];

   // ----------------------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      mapped  = 1'b1;
      if (addr_hit(paddr, `ZSM_IDX_WHITE_PIXEL_COUNT_1)) begin
         rd_byte = st_r.white_pixel_count_1_r;
      end else if (addr_hit(paddr, `ZSM_IDX_WHITE_PIXEL_COUNT_2)) begin
         rd_byte = st_r.white_pixel_count_2_r;
      end else if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_1_TO_4)) begin
         rd_byte = st_r.zone_select_r[0];
      end else if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_5_TO_8)) begin
         rd_byte = st_r.zone_select_r[1];
      end else if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_9_TO_12)) begin
         rd_byte = st_r.zone_select_r[2];
      end else if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_13_TO_16)) begin
         rd_byte = st_r.zone_select_r[3];
      end else if (addr_hit(paddr, `ZSM_IDX_OVERLAY_SHIFT_SELECT)) begin
         rd_byte = st_r.overlay_shift_select_r;
      end else if (addr_hit(paddr, `ZSM_IDX_SERIAL_INPUT_MONITOR)) begin
         rd_byte = serial_input_bytes[monitor_selector];
      end else if (addr_hit(paddr, `ZSM_IDX_OVERLAY_ONE_MONITOR)) begin
         rd_byte = mon_one;
      end else if (addr_hit(paddr, `ZSM_IDX_OVERLAY_TWO_MONITOR)) begin
         rd_byte = mon_two;
      end else begin
         mapped = 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin
      st_nxt          = st_r;
      st_nxt.pready_r = access;
      st_nxt.pslverr_r = access && !mapped;
      st_nxt.prdata_r = (access && !pwrite) ? {24'h0000_00, rd_byte} : 32'h0000_0000;
      st_nxt.func_on_r = func_src[`ZSM_FUNC_MSB];
      if (wr_en) begin
         // monitors have no storage, so writes to them fall through untouched
         if (addr_hit(paddr, `ZSM_IDX_WHITE_PIXEL_COUNT_1)) begin
            st_nxt.white_pixel_count_1_r = pwdata[7:0];
         end
         if (addr_hit(paddr, `ZSM_IDX_WHITE_PIXEL_COUNT_2)) begin
            st_nxt.white_pixel_count_2_r = pwdata[7:0];
         end
         if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_1_TO_4)) begin
            st_nxt.zone_select_r[0] = pwdata[7:0];
         end
         if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_5_TO_8)) begin
            st_nxt.zone_select_r[1] = pwdata[7:0];
         end
         if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_9_TO_12)) begin
            st_nxt.zone_select_r[2] = pwdata[7:0];
         end
         if (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_13_TO_16)) begin
            st_nxt.zone_select_r[3] = pwdata[7:0];
         end
         if (addr_hit(paddr, `ZSM_IDX_OVERLAY_SHIFT_SELECT)) begin
            st_nxt.overlay_shift_select_r = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.white_pixel_count_1_r  <= `ZSM_RST_WHITE_PIXEL_COUNT_1;
         st_r.white_pixel_count_2_r  <= `ZSM_RST_WHITE_PIXEL_COUNT_2;
         st_r.zone_select_r          <= {4{`ZSM_RST_ZONE_SELECT}};
         st_r.overlay_shift_select_r <= `ZSM_RST_OVERLAY_SHIFT_SELECT;
         st_r.pready_r               <= 1'b0;
         st_r.pslverr_r              <= 1'b0;
         st_r.prdata_r               <= 32'h0000_0000;
         st_r.func_on_r              <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign pready               = st_r.pready_r;
   assign pslverr              = st_r.pslverr_r;
   assign prdata               = st_r.prdata_r;
   assign white_pixel_count_1  = st_r.white_pixel_count_1_r;
   assign white_pixel_count_2  = st_r.white_pixel_count_2_r;
   assign zone_mode            = st_r.zone_select_r;
   assign overlay_shift_select = st_r.overlay_shift_select_r;
   assign overlay_function_on  = st_r.func_on_r;

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   sequence s_wr_shift;
      psel && penable && pwrite && !pready && pstrb[0]
         && addr_hit(paddr, `ZSM_IDX_OVERLAY_SHIFT_SELECT);
   endsequence

   sequence s_rd(logic [7:0] idx);
      psel && penable && !pwrite && !pready && addr_hit(paddr, idx);
   endsequence

   sequence s_wr(logic [7:0] idx);
      psel && penable && pwrite && !pready && pstrb[0] && addr_hit(paddr, idx);
   endsequence

   sequence s_wr_nostrb(logic [7:0] idx);
      psel && penable && pwrite && !pready && !pstrb[0] && addr_hit(paddr, idx);
   endsequence

   a_zone_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && pstrb[0]
       && addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_1_TO_4))
      |=> (zone_mode[7:0] == $past(pwdata[7:0])))
      else $error("zone select write lost");

   a_serial_mon_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_SERIAL_INPUT_MONITOR)
      |=> (prdata[7:0] == $past(serial_input_bytes[monitor_selector])) && pready)
      else $error("serial input monitor read wrong");

   a_func_off_flag: assert property (@(posedge pclk) disable iff (!presetn)
      !overlay_one_sources[0][7] |=> !overlay_function_on)
      else $error("overlay function not off for 0x");

   a_one_mon_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_OVERLAY_ONE_MONITOR) ##0 (monitor_selector == `ZSM_SEL_OVERLAY_ONE_BITMAP)
      |=> prdata[7:6] == $past(overlay_one_sources[1][7:6]))
      else $error("bitmap 1 opacity read wrong");

   a_win2_lsb_pack: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_OVERLAY_TWO_MONITOR) ##0 (monitor_selector == `ZSM_SEL_WIN2_LSBS)
      |=> prdata[7:0] == {$past(win2_vstart_lsbs), $past(win2_vstop_lsbs),
                          $past(win2_hstart_lsbs), $past(win2_hstop_lsbs)})
      else $error("window 2 lsb packing wrong");

   a_line_mem_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_OVERLAY_TWO_MONITOR) ##0 (monitor_selector == `ZSM_SEL_LINE_MEM_2)
      |=> prdata[7:0] == $past(line_mem_len_2))
      else $error("line memory length read wrong");

   a_shift_rw: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr_shift |=> ##1 (overlay_shift_select == $past(pwdata[7:0], 2)))
      else $error("shift select write lost");

   a_mon_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready
       && addr_hit(paddr, `ZSM_IDX_OVERLAY_TWO_MONITOR))
      |=> $stable(white_pixel_count_1) && $stable(zone_mode)
          && $stable(overlay_shift_select) && !pslverr)
      else $error("monitor write changed state");

   // ----------------------------------------------------------------------------
   // zone select and shift checks
   // ----------------------------------------------------------------------------
   a_zone_two_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(`ZSM_IDX_ZONE_SELECT_5_TO_8)
      |=> zone_mode[15:8] == $past(pwdata[7:0]))
      else $error("zone select 5 to 8 write lost");

   a_zone_three_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(`ZSM_IDX_ZONE_SELECT_9_TO_12)
      |=> zone_mode[23:16] == $past(pwdata[7:0]))
      else $error("zone select 9 to 12 write lost");

   a_zone_four_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(`ZSM_IDX_ZONE_SELECT_13_TO_16)
      |=> zone_mode[31:24] == $past(pwdata[7:0]))
      else $error("zone select 13 to 16 write lost");

   a_strobe_off_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr_nostrb(`ZSM_IDX_ZONE_SELECT_13_TO_16) |=> $stable(zone_mode))
      else $error("write without low strobe changed zone select");

   // zone fields only move on a strobed zone write
   a_zone_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite && !pready && pstrb[0]
        && (addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_1_TO_4)
            || addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_5_TO_8)
            || addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_9_TO_12)
            || addr_hit(paddr, `ZSM_IDX_ZONE_SELECT_13_TO_16)))
      |=> $stable(zone_mode))
      else $error("zone select moved without a write");

   a_shift_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite && !pready && pstrb[0]
        && addr_hit(paddr, `ZSM_IDX_OVERLAY_SHIFT_SELECT))
      |=> $stable(overlay_shift_select))
      else $error("shift select moved without a write");

   // ----------------------------------------------------------------------------
   // monitor checks
   // ----------------------------------------------------------------------------
   a_ovl_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_OVERLAY_ONE_MONITOR) ##0 (monitor_selector == `ZSM_SEL_OVERLAY_CONTROL)
      |=> prdata[7:0] == $past(overlay_one_sources[0]))
      else $error("overlay control read wrong");

   a_func_on_flag: assert property (@(posedge pclk) disable iff (!presetn)
      overlay_one_sources[0][7] |=> overlay_function_on)
      else $error("overlay function not on for 1x");

   a_one_any_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_OVERLAY_ONE_MONITOR)
      |=> prdata[7:0] == $past(overlay_one_sources[monitor_selector]))
      else $error("overlay one monitor read wrong");

   a_two_other_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_OVERLAY_TWO_MONITOR) ##0 (monitor_selector != `ZSM_SEL_WIN2_LSBS
         && monitor_selector != `ZSM_SEL_LINE_MEM_2)
      |=> prdata[7:0] == $past(overlay_two_sources[monitor_selector]))
      else $error("overlay two monitor read wrong");

   a_serial_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(`ZSM_IDX_SERIAL_INPUT_MONITOR)
      |=> $stable(white_pixel_count_2) && $stable(zone_mode) && !pslverr)
      else $error("serial monitor write changed state");

   a_one_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(`ZSM_IDX_OVERLAY_ONE_MONITOR)
      |=> $stable(white_pixel_count_1) && $stable(overlay_shift_select) && !pslverr)
      else $error("overlay one monitor write changed state");

   a_mon_read_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(`ZSM_IDX_SERIAL_INPUT_MONITOR) |=> pready && !pslverr)
      else $error("serial monitor read refused");

   // ----------------------------------------------------------------------------
   // answer checks
   // ----------------------------------------------------------------------------
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held past one cycle");

   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error raised without ready");

   a_rdata_idle_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero between answers");

   a_rdata_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");

   a_hole_read_err: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd(8'hc7) |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   a_hole_write_err: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(8'hec) |=> pready && pslverr)
      else $error("unmapped write not refused");

endmodule

/* design/zsm_pkg.sv */
/*
 Types of the zone select and readback monitor block.
 Assumes zsm_defines.svh is available for constants.
*/
package zsm_pkg;
   typedef logic [7:0] zsm_byte_type;

   typedef struct packed {
      zsm_byte_type       white_pixel_count_1_r;
      zsm_byte_type       white_pixel_count_2_r;
      zsm_byte_type [3:0] zone_select_r;
      zsm_byte_type       overlay_shift_select_r;
      logic               func_on_r;
      logic               pready_r;
      logic               pslverr_r;
      logic [31:0]        prdata_r;
   } zsm_state_type;
endpackage

/* tb/zsm_monitor_regs_test.sv */
/*
 Self-checking bench for the zone select and readback monitor bank over APB.
 Assumes zsm_pkg and zsm_defines.svh are compiled alongside; monitor sources driven here.
*/
`timescale 1ns/10ps
`include "zsm_defines.svh"
module zsm_monitor_regs_test import zsm_pkg::*; ;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, fn_on;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, zone_mode, rd;
   logic [3:0]         sel, strb;
   logic               err;
   zsm_byte_type [15:0] ser_b, ov1_b, ov2_b;
   logic [1:0]         vsa, vso, hsa, hso;
   zsm_byte_type       lm2, wpc1, wpc2, shift;
   int                 fail_count, n_compared;

   zsm_monitor_regs zsm_monitor_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .monitor_selector(sel),
      .serial_input_bytes(ser_b), .overlay_one_sources(ov1_b), .overlay_two_sources(ov2_b),
      .win2_vstart_lsbs(vsa), .win2_vstop_lsbs(vso), .win2_hstart_lsbs(hsa),
      .win2_hstop_lsbs(hso), .line_mem_len_2(lm2), .white_pixel_count_1(wpc1),
      .white_pixel_count_2(wpc2), .zone_mode(zone_mode), .overlay_shift_select(shift),
      .overlay_function_on(fn_on));

   always #4 pclk = ~pclk;

   // ---------------------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // request held until pready is sampled high; only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      check(n, 32'd2, "answer latency");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
      apb(1'b0, idx, 32'h0000_0000);
      check({err, rd}, {1'b0, 24'h00_0000, exp}, what);
   endtask

   task automatic pick(input logic [3:0] s);
      @(posedge pclk);
      sel <= s;
   endtask

   // ---------------------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------------------
   task automatic t_reset;
      check({wpc1, wpc2, shift}, {8'h64, 8'h80, 8'h00}, "reset outputs");
      check(zone_mode, 32'hffff_ffff, "zone reset");
      rdchk(`ZSM_IDX_WHITE_PIXEL_COUNT_1, 8'h64, "wpc1 reset");
      rdchk(`ZSM_IDX_WHITE_PIXEL_COUNT_2, 8'h80, "wpc2 reset");
      rdchk(`ZSM_IDX_ZONE_SELECT_9_TO_12, 8'hff, "zone reset");
      rdchk(`ZSM_IDX_OVERLAY_SHIFT_SELECT, 8'h00, "shift reset");
      $display("test reset done");
   endtask

   task automatic t_rw;
      apb(1'b1, `ZSM_IDX_WHITE_PIXEL_COUNT_1, 32'hffff_ff12);
      apb(1'b1, `ZSM_IDX_WHITE_PIXEL_COUNT_2, 32'h0000_0034);
      apb(1'b1, `ZSM_IDX_ZONE_SELECT_1_TO_4, 32'h0000_00e4);
      apb(1'b1, `ZSM_IDX_ZONE_SELECT_5_TO_8, 32'h0000_001b);
      apb(1'b1, `ZSM_IDX_ZONE_SELECT_9_TO_12, 32'h0000_005a);
      apb(1'b1, `ZSM_IDX_ZONE_SELECT_13_TO_16, 32'h0000_0096);
      apb(1'b1, `ZSM_IDX_OVERLAY_SHIFT_SELECT, 32'h0000_0003);
      check(zone_mode, 32'h965a_1be4, "zone fields");
      check({wpc1, wpc2, shift}, {8'h12, 8'h34, 8'h03}, "rw outputs");
      rdchk(`ZSM_IDX_WHITE_PIXEL_COUNT_1, 8'h12, "wpc1 rb");
      rdchk(`ZSM_IDX_ZONE_SELECT_5_TO_8, 8'h1b, "zone rb");
      rdchk(`ZSM_IDX_OVERLAY_SHIFT_SELECT, 8'h03, "shift rb");
      $display("test read write done");
   endtask

   task automatic t_serial;
      for (int s = 0; s < 16; s++) begin
         pick(s[3:0]);
         rdchk(`ZSM_IDX_SERIAL_INPUT_MONITOR, 8'h10 + s[7:0], "serial mon");
      end
      $display("test serial monitor done");
   endtask

   task automatic t_ovl;
      pick(4'h0);
      for (int f = 0; f < 4; f++) begin
         ov1_b[0] <= {f[1:0], 6'h15};
         rdchk(`ZSM_IDX_OVERLAY_ONE_MONITOR, {f[1:0], 6'h15}, "ovl control");
         check(fn_on, f[1], "function on");
      end
      pick(4'h1);
      for (int o = 0; o < 4; o++) begin
         ov1_b[1] <= {o[1:0], 6'h2a};
         rdchk(`ZSM_IDX_OVERLAY_ONE_MONITOR, {o[1:0], 6'h2a}, "opacity");
      end
      pick(4'h5);
      rdchk(`ZSM_IDX_OVERLAY_TWO_MONITOR, 8'hd8, "win2 lsbs");
      pick(4'h6);
      rdchk(`ZSM_IDX_OVERLAY_TWO_MONITOR, 8'h5c, "line mem 2");
      pick(4'h2);
      rdchk(`ZSM_IDX_OVERLAY_TWO_MONITOR, 8'h72, "ovl2 other");
      $display("test overlay monitors done");
   endtask

   // monitor writes must vanish silently; unmapped holes answer with an error
   task automatic t_refuse;
      pick(4'h3);
      apb(1'b1, `ZSM_IDX_SERIAL_INPUT_MONITOR, 32'h0000_00aa);
      check(err, 1'b0, "ro write err");
      apb(1'b1, `ZSM_IDX_OVERLAY_ONE_MONITOR, 32'h0000_00aa);
      apb(1'b1, `ZSM_IDX_OVERLAY_TWO_MONITOR, 32'h0000_00aa);
      check({err, wpc1, shift}, {1'b0, 8'h12, 8'h03}, "ro write inert");
      rdchk(`ZSM_IDX_SERIAL_INPUT_MONITOR, 8'h13, "ro write kept");
      rdchk(`ZSM_IDX_OVERLAY_ONE_MONITOR, 8'h43, "ro write kept");
      apb(1'b0, 8'hc7, 32'h0000_0000);
      check({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
      apb(1'b1, 8'hec, 32'h0000_0055);
      check(err, 1'b1, "unmapped write");
      strb <= 4'h0;
      apb(1'b1, `ZSM_IDX_ZONE_SELECT_13_TO_16, 32'h0000_0000);
      strb <= 4'h1;
      check(zone_mode, 32'h965a_1be4, "strobe off write");
      $display("test refusals done");
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, paddr, pwdata, sel} = '0;
      strb = 4'h1;
      for (int i = 0; i < 16; i++) begin
         ser_b[i] = 8'h10 + i[7:0];
         ov1_b[i] = 8'h40 + i[7:0];
         ov2_b[i] = 8'h70 + i[7:0];
      end
      {vsa, vso, hsa, hso} = 8'hd8;
      lm2 = 8'h5c;
      fail_count = 0;
      n_compared = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rw();
      t_serial();
      t_ovl();
      t_refuse();
      report_and_stop();
   end

   // whole sequence is a few hundred cycles; far longer means a hang
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
endmodule
